// ---- design/lin_frame_decoder_trigger.sv ----
// LIN bus frame decoder, trigger unit and APB register slave
//
// Operation
// - Bytes: start, eight data LSB first, stop
// - No per-byte parity bit is expected
// - Polarity setting inverts the sampled line
// - Version setting selects checksum form
// - Bit rate programmable, fast user rates
// - Frame-begin trigger at sync stop bit
// - Wake trigger after wake-up frame seen
// - Checksum recomputed, mismatch flagged
// - Identifier parity bits 6,7 verified
// - Bad sync field flagged and triggers
// - Error trigger enables per error type
// - Identifier trigger: single value or range
// - Don't-care pattern allows only equal/unequal
// - Definite pattern also allows greater/less
// - Pattern bits are one, zero, don't-care
// - Byte-entry mode masks whole bytes only
// - Identifier plus data bytes both must match
// - Combined trigger offers equal/unequal only
// - Record: time, id, length, data, checksum
// - Record carries exactly one status
// - Boundary header-only frames marked no data
`timescale 1ns/1ps
module lin_frame_decoder_trigger #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lin_in,
  output logic trigger,
  output logic record_valid,
  output lin_pkg::rec_t record
);
  import lin_pkg::*;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_HOLD}
    rx_st_t;
  typedef enum logic [1:0] {FR_IDLE, FR_SYNC, FR_PID, FR_DATA} fr_st_t;

  // Expected identifier parity, {P1, P0}
  function automatic logic [1:0] pid_parity(input logic [5:0] id);
    pid_parity = {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
                  id[0] ^ id[1] ^ id[2] ^ id[4]};
  endfunction

  // Eight-bit add with end-around carry
  function automatic logic [7:0] add_carry(input logic [7:0] a,
                                           input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    add_carry = s[7:0] + {7'h00, s[8]};
  endfunction

  ctrl_t ctrl_q; // Configuration
  logic [15:0] div_q; // Clocks per bit
  logic [5:0] idpat_q, idcare_q, idhi_q; // Identifier pattern
  logic [63:0] dpat_q, dcare_q; // Data pattern, 1 = care
  logic line_q; // Sampled, polarity-corrected line
  rx_st_t rx_st_q;
  logic [15:0] cnt_q; // Bit timer
  logic [2:0] bidx_q; // Data bit index
  logic [7:0] shift_q, byte_q;
  logic byte_done_q, ferr_q;
  logic [17:0] gap_lim;
  logic [18:0] gap_q; // Idle-time counter
  logic gap_ev_q;
  fr_st_t fr_st_q;
  logic [7:0] pid_q;
  logic par_bad_q;
  logic [3:0] nbytes_q;
  logic [7:0] buf_q [MAX_BYTES];
  logic [7:0] sum_q, prev_sum_q;
  logic [31:0] ts_q, start_ts_q, trig_ts_q;
  logic access, wr_commit, cap_stop;

  // APB phase decode; write lands on the edge that sees pready high
  assign access = psel & penable;
  assign wr_commit = access & pready & pwrite;
  assign cap_stop = wr_commit & (paddr[7:0] == OFS_CTRL) &
                    pwdata[CAP_STOP_BIT];
  assign gap_lim = {div_q, 2'b00};

  // Free-running timestamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_q <= 32'h0000_0000;
    end else begin
      ts_q <= ts_q + 32'h0000_0001;
    end
  end

  // Line sampling; a disabled decoder sees a recessive line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q <= 1'b1;
    end else begin
      line_q <= ctrl_q.enable ? (lin_in ^ ctrl_q.pol_low) : 1'b1;
    end
  end

  // Byte deframer, mid-bit sampling from the bit divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= RX_IDLE;
      cnt_q <= 16'h0000;
      bidx_q <= 3'h0;
      shift_q <= 8'h00;
      byte_q <= 8'h00;
      byte_done_q <= 1'b0;
      ferr_q <= 1'b0;
      gap_q <= 19'h00000;
      gap_ev_q <= 1'b0;
    end else begin
      byte_done_q <= 1'b0;
      gap_ev_q <= 1'b0;
      unique case (rx_st_q)
        RX_IDLE: begin
          if (!line_q) begin
            // Falling edge: aim at the middle of the start bit; the
            // register and detect delay is taken off, else short bit
            // periods get sampled at their very end
            rx_st_q <= RX_START;
            cnt_q <= (div_q >> 1) - EDGE_LAT;
            gap_q <= 19'h00000;
          end else if (gap_q <= {1'b0, gap_lim}) begin
            gap_q <= gap_q + 19'h00001;
            gap_ev_q <= (gap_q == {1'b0, gap_lim});
          end
        end
        RX_START: begin
          if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else if (!line_q) begin
            rx_st_q <= RX_DATA;
            cnt_q <= div_q - 16'h0001;
            bidx_q <= 3'h0;
          end else begin
            // Glitch shorter than half a bit
            rx_st_q <= RX_IDLE;
          end
        end
        RX_DATA: begin
          if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            shift_q <= {line_q, shift_q[7:1]};
            cnt_q <= div_q - 16'h0001;
            bidx_q <= bidx_q + 3'h1;
            if (bidx_q == 3'h7) begin
              rx_st_q <= RX_STOP; // No parity bit follows
            end
          end
        end
        RX_STOP: begin
          if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            byte_done_q <= 1'b1;
            byte_q <= shift_q;
            ferr_q <= ~line_q;
            // A long dominant break must not restart the deframer
            rx_st_q <= line_q ? RX_IDLE : RX_HOLD;
          end
        end
        RX_HOLD: begin
          if (line_q) begin
            rx_st_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  logic is_break, ev_sof, ev_sync_err, ev_pid, pid_bad, ev_wake;
  logic ev_end, ev_hdr_only, chk_ok, classic_ok, enh_ok, diag;
  logic [7:0] last_b;
  logic [3:0] len;
  logic [63:0] data_vec;

  // Frame-level events
  always_comb begin
    is_break = byte_done_q & ferr_q & (byte_q == 8'h00);
    ev_sof = byte_done_q & ~is_break & (fr_st_q == FR_SYNC) &
             (byte_q == SYNC_VAL) & ~ferr_q;
    ev_sync_err = byte_done_q & ~is_break & (fr_st_q == FR_SYNC) &
                  ~ev_sof;
    ev_pid = byte_done_q & ~is_break & (fr_st_q == FR_PID);
    pid_bad = ev_pid & (byte_q[7:6] != pid_parity(byte_q[5:0]));
    // Break with no sync before the line rests
    ev_wake = gap_ev_q & (fr_st_q == FR_SYNC);
    ev_end = (gap_ev_q | is_break) & (fr_st_q == FR_DATA) &
             (nbytes_q != 4'h0);
    ev_hdr_only = (gap_ev_q | is_break) & ((fr_st_q == FR_PID) |
                  ((fr_st_q == FR_DATA) & (nbytes_q == 4'h0)));
    len = (nbytes_q == 4'h0) ? 4'h0 : nbytes_q - 4'h1;
    last_b = buf_q[len];
    // Checksum: classic over data, enhanced adds the protected id
    classic_ok = (~prev_sum_q == last_b);
    enh_ok = (~add_carry(prev_sum_q, pid_q) == last_b);
    diag = (pid_q[5:0] == DIAG_ID_A) | (pid_q[5:0] == DIAG_ID_B);
    unique case (ctrl_q.version)
      VER_1X: chk_ok = classic_ok;
      VER_2X, VER_VEH: chk_ok = diag ? classic_ok : enh_ok;
      VER_ANY: chk_ok = classic_ok | enh_ok;
    endcase
    for (int i = 0; i < 8; i++) begin
      data_vec[i*8 +: 8] = (4'(i) < len) ? buf_q[i] : 8'h00;
    end
  end

  // Frame sequencer: break, sync, identifier, response bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fr_st_q <= FR_IDLE;
      pid_q <= 8'h00;
      par_bad_q <= 1'b0;
      nbytes_q <= 4'h0;
      sum_q <= 8'h00;
      prev_sum_q <= 8'h00;
      start_ts_q <= 32'h0000_0000;
      for (int i = 0; i < MAX_BYTES; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (cap_stop) begin
      fr_st_q <= FR_IDLE;
    end else if (is_break) begin
      fr_st_q <= FR_SYNC;
      start_ts_q <= ts_q;
      nbytes_q <= 4'h0;
    end else begin
      unique case (fr_st_q)
        FR_IDLE: ;
        FR_SYNC: begin
          if (byte_done_q) begin
            fr_st_q <= ev_sof ? FR_PID : FR_IDLE;
          end else if (gap_ev_q) begin
            fr_st_q <= FR_IDLE;
          end
        end
        FR_PID: begin
          if (byte_done_q) begin
            fr_st_q <= FR_DATA;
            pid_q <= byte_q;
            par_bad_q <= pid_bad;
            sum_q <= 8'h00;
            prev_sum_q <= 8'h00;
          end else if (gap_ev_q) begin
            fr_st_q <= FR_IDLE;
          end
        end
        FR_DATA: begin
          if (byte_done_q && nbytes_q < MAX_BYTES_4) begin
            buf_q[nbytes_q] <= byte_q;
            nbytes_q <= nbytes_q + 4'h1;
            prev_sum_q <= sum_q;
            sum_q <= add_carry(sum_q, byte_q);
          end else if (gap_ev_q) begin
            fr_st_q <= FR_IDLE;
          end
        end
      endcase
    end
  end

  logic id_eq, id_full, id_hit, data_eq, idp_hit, err_hit, fire;
  logic [5:0] id_care, id_rx;
  logic [7:0] cb;

  // Trigger condition evaluation
  always_comb begin
    id_rx = ev_pid ? byte_q[5:0] : pid_q[5:0];
    // Byte entry masks the identifier as a whole
    id_care = ctrl_q.byte_mode ? {6{|idcare_q}} : idcare_q;
    id_eq = ((id_rx ^ idpat_q) & id_care) == 6'h00;
    id_full = &id_care;
    unique case (ctrl_q.cmp_op)
      CMP_EQ: id_hit = id_eq;
      CMP_NE: id_hit = ~id_eq;
      CMP_GT: id_hit = id_full & (id_rx > idpat_q);
      CMP_LT: id_hit = id_full & (id_rx < idpat_q);
      CMP_RANGE: id_hit = id_full & (id_rx >= idpat_q) &
                          (id_rx <= idhi_q);
      default: id_hit = 1'b0;
    endcase
    // Data bytes beyond the received length fail if cared for
    data_eq = 1'b1;
    for (int i = 0; i < 8; i++) begin
      cb = ctrl_q.byte_mode ? {8{|dcare_q[i*8 +: 8]}} :
                              dcare_q[i*8 +: 8];
      if ((4'(i) >= len) ? (cb != 8'h00) :
          (((data_vec[i*8 +: 8] ^ dpat_q[i*8 +: 8]) & cb) != 8'h00)) begin
        data_eq = 1'b0;
      end
    end
    idp_hit = ev_end & ((ctrl_q.cmp_op == CMP_EQ) ? id_eq :
              (ctrl_q.cmp_op == CMP_NE) ? ~id_eq : 1'b0) &
              (ctrl_q.data_ne ? ~data_eq : data_eq);
    err_hit = (ev_end & ~par_bad_q & ~chk_ok & ctrl_q.err_chk_en) |
              (pid_bad & ctrl_q.err_par_en) |
              (ev_sync_err & ctrl_q.err_sync_en);
    unique case (ctrl_q.trig_mode)
      TRG_FRAME_BEGIN: fire = ev_sof;
      TRG_WAKE: fire = ev_wake;
      TRG_ERROR: fire = err_hit;
      TRG_ID: fire = ev_pid & id_hit;
      TRG_IDENTIFIER_PAYLOAD: fire = idp_hit;
      default: fire = 1'b0;
    endcase
  end

  // Trigger pulse and trigger timestamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger <= 1'b0;
      trig_ts_q <= 32'h0000_0000;
    end else begin
      trigger <= fire;
      if (fire) begin
        trig_ts_q <= ts_q;
      end
    end
  end

  // Frame record; capture stop outranks every bus event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      record_valid <= 1'b0;
      record <= '0;
    end else begin
      record_valid <= 1'b0;
      if (cap_stop ? (fr_st_q != FR_IDLE) :
          (ev_sync_err | ev_wake | ev_hdr_only | ev_end)) begin
        record_valid <= 1'b1;
        record.id <= pid_q[5:0];
        record.len <= len;
        record.chks <= last_b;
        record.data <= data_vec;
        record.start_time <= start_ts_q - trig_ts_q;
        if (cap_stop) begin
          record.status <= ((fr_st_q == FR_DATA) && (nbytes_q != 4'h0)) ?
                           ST_TRUNCATED_FRAME : ST_NO_DATA;
        end else if (ev_sync_err) begin
          record.status <= ST_SYNC_ERR;
        end else if (ev_wake) begin
          record.status <= ST_BUS_ROUSE_FRAME;
        end else if (ev_hdr_only) begin
          record.status <= ST_NO_DATA;
        end else begin
          record.status <= par_bad_q ? ST_IDENTIFIER_CHECK_FAIL :
                           chk_ok ? ST_VALID : ST_CHECKSUM_ERR;
        end
      end
    end
  end

  logic [31:0] rdata;
  logic mapped;

  // Read mux and address decode
  always_comb begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr[7:0])
      OFS_CTRL: rdata = 32'(ctrl_q);
      OFS_BITDIV: rdata = {16'h0000, div_q};
      OFS_IDPAT: begin
        rdata[IDP_PAT_LSB +: 6] = idpat_q;
        rdata[IDP_CARE_LSB +: 6] = idcare_q;
        rdata[IDP_HI_LSB +: 6] = idhi_q;
      end
      OFS_DPAT_LO: rdata = dpat_q[31:0];
      OFS_DPAT_HI: rdata = dpat_q[63:32];
      OFS_DCARE_LO: rdata = dcare_q[31:0];
      OFS_DCARE_HI: rdata = dcare_q[63:32];
      OFS_REC_INFO: begin
        rdata[RI_ID_LSB +: 6] = record.id;
        rdata[RI_LEN_LSB +: 4] = record.len;
        rdata[RI_CHK_LSB +: 8] = record.chks;
        rdata[RI_ST_LSB +: 3] = record.status;
        rdata[RI_BUSY_BIT] = (fr_st_q != FR_IDLE);
      end
      OFS_REC_DLO: rdata = record.data[31:0];
      OFS_REC_DHI: rdata = record.data[63:32];
      OFS_REC_TIME: rdata = record.start_time;
      default: mapped = 1'b0;
    endcase
    if (paddr[ADDR_W-1:0] != ADDR_W'(paddr[7:0])) begin
      mapped = 1'b0;
    end
  end

  // APB answer: one wait state, data and error with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access & ~pready;
      if (access & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata;
        pslverr <= ~mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      div_q <= DEF_DIV;
      idpat_q <= 6'h00;
      idcare_q <= IDCARE_RST;
      idhi_q <= 6'h00;
      dpat_q <= 64'h0;
      dcare_q <= 64'h0;
    end else if (wr_commit) begin
      unique case (paddr[7:0])
        OFS_CTRL: ctrl_q <= ctrl_t'(pwdata[$bits(ctrl_t)-1:0]);
        // Clamped so half-bit sampling stays meaningful
        OFS_BITDIV: div_q <= (pwdata[15:0] < MIN_DIV) ? MIN_DIV :
                             pwdata[15:0];
        OFS_IDPAT: begin
          idpat_q <= pwdata[IDP_PAT_LSB +: 6];
          idcare_q <= pwdata[IDP_CARE_LSB +: 6];
          idhi_q <= pwdata[IDP_HI_LSB +: 6];
        end
        OFS_DPAT_LO: dpat_q[31:0] <= pwdata;
        OFS_DPAT_HI: dpat_q[63:32] <= pwdata;
        OFS_DCARE_LO: dcare_q[31:0] <= pwdata;
        OFS_DCARE_HI: dcare_q[63:32] <= pwdata;
        default: ;
      endcase
    end
  end

  // Checks
  property p_sof_fire;
    @(posedge pclk) disable iff (!presetn)
    (ev_sof && ctrl_q.trig_mode == TRG_FRAME_BEGIN) |=> trigger;
  endproperty
  a_sof_fire: assert property (p_sof_fire)
    else $error("frame begin trigger missing");

  property p_wake_fire;
    @(posedge pclk) disable iff (!presetn)
    (ev_wake && ctrl_q.trig_mode == TRG_WAKE) |=>
      trigger && record_valid && record.status == ST_BUS_ROUSE_FRAME;
  endproperty
  a_wake_fire: assert property (p_wake_fire)
    else $error("wake frame not reported");

  property p_sync_rec;
    @(posedge pclk) disable iff (!presetn)
    (byte_done_q && fr_st_q == FR_SYNC && !is_break &&
     byte_q != SYNC_VAL) |=> record_valid && record.status == ST_SYNC_ERR;
  endproperty
  a_sync_rec: assert property (p_sync_rec)
    else $error("sync error not recorded");

  property p_par_flag;
    @(posedge pclk) disable iff (!presetn)
    (ev_pid && byte_q[6] != ^{byte_q[0], byte_q[1], byte_q[2], byte_q[4]})
      |=> par_bad_q;
  endproperty
  a_par_flag: assert property (p_par_flag)
    else $error("parity fault not flagged");

  property p_chk_rec;
    @(posedge pclk) disable iff (!presetn)
    (ev_end && !cap_stop && !par_bad_q && ctrl_q.version == VER_1X &&
     ~prev_sum_q != last_b) |=> record.status == ST_CHECKSUM_ERR;
  endproperty
  a_chk_rec: assert property (p_chk_rec)
    else $error("checksum mismatch not recorded");

  property p_masked_no_gt;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q.trig_mode == TRG_ID && ctrl_q.cmp_op == CMP_GT &&
     !(&id_care)) |=> !trigger;
  endproperty
  a_masked_no_gt: assert property (p_masked_no_gt)
    else $error("ordered compare with masked pattern");

  property p_trunc;
    @(posedge pclk) disable iff (!presetn)
    (cap_stop && fr_st_q == FR_DATA && nbytes_q != 4'h0) |=>
      record_valid && record.status == ST_TRUNCATED_FRAME;
  endproperty
  a_trunc: assert property (p_trunc)
    else $error("truncated frame not marked");

  property p_byte_time;
    @(posedge pclk) disable iff (!presetn)
    (rx_st_q == RX_IDLE && !line_q && div_q == MIN_DIV) |->
      ##[37:39] byte_done_q;
  endproperty
  a_byte_time: assert property (p_byte_time)
    else $error("byte length not ten bit times");

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
    (access && !pready) |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer late");

  c_sof: cover property (@(posedge pclk) disable iff (!presetn) ev_sof);
  c_valid: cover property (@(posedge pclk) disable iff (!presetn)
    record_valid && record.status == ST_VALID);
  c_idp: cover property (@(posedge pclk) disable iff (!presetn)
    trigger && ctrl_q.trig_mode == TRG_IDENTIFIER_PAYLOAD);
endmodule

// ---- design/lin_pkg.sv ----
// Shared constants, enumerations and carriers for the LIN frame decoder
package lin_pkg;
  // Sampling clock and default bit rate
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned DEF_BAUD = 19_200;
  localparam logic [15:0] DEF_DIV = 16'(CLK_HZ / DEF_BAUD);
  // Shortest usable bit period in clocks (half-bit sampling needs room)
  localparam logic [15:0] MIN_DIV = 16'h0004;
  // Clocks from a pin edge to its detection in the idle state
  localparam logic [15:0] EDGE_LAT = 16'h0002;
  // Silence of 2^GAP_SHIFT bit times closes a frame
  localparam int GAP_SHIFT = 2;
  // Fixed field values
  localparam logic [7:0] SYNC_VAL = 8'h55;
  localparam logic [5:0] DIAG_ID_A = 6'h3C;
  localparam logic [5:0] DIAG_ID_B = 6'h3D;
  // Response bytes kept: eight data plus checksum
  localparam int MAX_BYTES = 9;
  localparam logic [3:0] MAX_BYTES_4 = 4'h9;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BITDIV = 8'h04;
  localparam logic [7:0] OFS_IDPAT = 8'h08;
  localparam logic [7:0] OFS_DPAT_LO = 8'h0C;
  localparam logic [7:0] OFS_DPAT_HI = 8'h10;
  localparam logic [7:0] OFS_DCARE_LO = 8'h14;
  localparam logic [7:0] OFS_DCARE_HI = 8'h18;
  localparam logic [7:0] OFS_REC_INFO = 8'h1C;
  localparam logic [7:0] OFS_REC_DLO = 8'h20;
  localparam logic [7:0] OFS_REC_DHI = 8'h24;
  localparam logic [7:0] OFS_REC_TIME = 8'h28;
  // Field positions
  localparam int CAP_STOP_BIT = 15;
  localparam int IDP_PAT_LSB = 0;
  localparam int IDP_CARE_LSB = 8;
  localparam int IDP_HI_LSB = 16;
  localparam int RI_ID_LSB = 0;
  localparam int RI_LEN_LSB = 8;
  localparam int RI_CHK_LSB = 12;
  localparam int RI_ST_LSB = 24;
  localparam int RI_BUSY_BIT = 31;
  // Reset values
  localparam logic [5:0] IDCARE_RST = 6'h3F;
  // Protocol version selection
  typedef enum logic [1:0] {VER_1X, VER_2X, VER_VEH, VER_ANY} version_t;
  // Trigger source selection
  typedef enum logic [2:0] {
    TRG_OFF, TRG_FRAME_BEGIN, TRG_WAKE, TRG_ERROR, TRG_ID,
    TRG_IDENTIFIER_PAYLOAD
  } trig_mode_t;
  // Identifier comparison
  typedef enum logic [2:0] {CMP_EQ, CMP_NE, CMP_GT, CMP_LT, CMP_RANGE} cmp_t;
  // Per-frame result
  typedef enum logic [2:0] {
    ST_VALID, ST_SYNC_ERR, ST_CHECKSUM_ERR, ST_IDENTIFIER_CHECK_FAIL,
    ST_BUS_ROUSE_FRAME, ST_TRUNCATED_FRAME, ST_NO_DATA
  } status_t;
  // Control register, bit 0 is enable
  typedef struct packed {
    logic data_ne;
    logic byte_mode;
    logic err_sync_en;
    logic err_par_en;
    logic err_chk_en;
    cmp_t cmp_op;
    trig_mode_t trig_mode;
    version_t version;
    logic pol_low;
    logic enable;
  } ctrl_t;
  // Decoded frame record
  typedef struct packed {
    status_t status;
    logic [3:0] len;
    logic [5:0] id;
    logic [7:0] chks;
    logic [63:0] data;
    logic [31:0] start_time;
  } rec_t;
endpackage

// ---- sim/lin_node.sv ----
// Behavioural LIN master and slave pair that drives the observed line
`timescale 1ns/1ps
module lin_node #(
  parameter int DIV = 8
) (
  input wire logic pclk,
  input wire logic inv,
  output logic lin_out
);
  logic lvl = 1'h1; // Recessive while idle, as with the bus pull-up
  // Line seen by the decoder; inversion mimics the other conductor
  assign lin_out = lvl ^ inv;
  // Hold one level for n bit times, changed just after an edge
  task automatic hold(input logic v, input int n);
    lvl <= v;
    repeat (n * DIV) @(posedge pclk);
  endtask
  // Start bit, eight data bits LSB first, stop bit, no parity
  task automatic put_byte(input logic [7:0] b);
    hold(1'h0, 1);
    for (int k = 0; k < 8; k++) hold(b[k], 1);
    hold(1'h1, 1);
  endtask
  // Long dominant stretch then a recessive delimiter
  task automatic put_break();
    hold(1'h0, 13);
    hold(1'h1, 1);
  endtask
endmodule

// ---- sim/lin_frame_decoder_trigger_bench.sv ----
// Self-checking bench for the LIN frame decoder and trigger unit
`timescale 1ns/1ps
module lin_frame_decoder_trigger_bench;
  import lin_pkg::*;
  logic pclk = 1'h0; // 25 MHz sampling clock
  logic presetn = 1'h0; // Active-low reset
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, lin_in, trigger, record_valid, er;
  logic inv = 1'h0; // Line inversion applied by the far side
  rec_t record;
  int err_count = 0;
  int n_checks = 0;
  int trg_n = 0; // Running count of trigger pulses
  int base, i;
  typedef struct {
    logic [15:0] ctrl;
    logic inv;
    logic [1:0] kind; // 0 full frame, 1 bad sync, 2 wake-up
    logic [7:0] pid, chk;
    status_t st;
    int trg;
  } row_t;
  // Control word, line sense, frame kind, expectations
  row_t rows [13] = '{
    '{16'h0011, 1'h0, 2'h0, 8'hC1, 8'hED, ST_VALID, 1},
    '{16'h0005, 1'h0, 2'h0, 8'hC1, 8'h2C, ST_VALID, 0},
    '{16'h000D, 1'h0, 2'h0, 8'hC1, 8'h2C, ST_VALID, 0},
    '{16'h0431, 1'h0, 2'h0, 8'hC1, 8'h2C, ST_CHECKSUM_ERR, 1},
    '{16'h0831, 1'h0, 2'h0, 8'h01, 8'hED, ST_IDENTIFIER_CHECK_FAIL, 1},
    '{16'h1031, 1'h0, 2'h1, 8'hC1, 8'hED, ST_SYNC_ERR, 1},
    '{16'h0021, 1'h0, 2'h2, 8'h00, 8'h00, ST_BUS_ROUSE_FRAME, 1},
    '{16'h0041, 1'h0, 2'h0, 8'hC1, 8'hED, ST_VALID, 1},
    '{16'h00C1, 1'h0, 2'h0, 8'hC1, 8'hED, ST_VALID, 0},
    '{16'h0013, 1'h1, 2'h0, 8'hC1, 8'hED, ST_VALID, 1},
    '{16'h0051, 1'h0, 2'h0, 8'hC1, 8'hED, ST_VALID, 1},
    '{16'h0141, 1'h0, 2'h0, 8'hC1, 8'hED, ST_VALID, 1},
    '{16'h0141, 1'h0, 2'h0, 8'hC1, 8'hED, ST_VALID, 0}
  };
  lin_frame_decoder_trigger uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lin_in(lin_in), .trigger(trigger), .record_valid(record_valid),
    .record(record));
  lin_node #(.DIV(4)) lin (.pclk(pclk), .inv(inv), .lin_out(lin_in));
  // Free-running clock
  initial begin
    forever #20 pclk = ~pclk;
  end
  // Count trigger pulses; one-cycle pulses are seen at each edge
  always @(posedge pclk) begin
    if (trigger === 1'h1) trg_n <= trg_n + 1;
  end
  // Verdict and end of run
  task automatic end_sim();
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // One idle edge, so a following call never re-drives psel at once
    @(posedge pclk);
  endtask
  // Wait for the next record; a missing one counts as a mismatch
  task automatic wait_rec();
    i = 0;
    while (record_valid !== 1'h1 && i < 400) begin
      @(posedge pclk);
      i++;
    end
    chk(32'(i < 400), 32'h1);
  endtask
  // Configure, send one frame, check record and trigger count
  task automatic run(input row_t r);
    apb(1'h1, OFS_CTRL, 32'(r.ctrl & 16'hFFFE), rd, er);
    inv <= r.inv;
    repeat (40) @(posedge pclk);
    apb(1'h1, OFS_CTRL, 32'(r.ctrl), rd, er);
    base = trg_n;
    lin.put_break();
    if (r.kind != 2'h2) lin.put_byte((r.kind == 2'h1) ? 8'h54 : SYNC_VAL);
    if (r.kind == 2'h0) begin
      lin.put_byte(r.pid);
      lin.put_byte(8'h12);
      lin.put_byte(r.chk);
    end
    wait_rec();
    chk(32'(record.status), 32'(r.st));
    // Break start to sync start is fourteen bit times of four clocks
    if (r.ctrl[6:4] == 3'h1) begin
      chk(record.start_time, 32'hFFFFFFC8);
    end
    if (r.kind == 2'h0) begin
      chk(32'({record.id, record.len, record.chks, record.data[7:0]}),
          32'({r.pid[5:0], 4'h1, r.chk, 8'h12}));
    end
    repeat (80) @(posedge pclk);
    chk(32'(trg_n - base), 32'(r.trg));
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, OFS_BITDIV, 32'h0, rd, er);
    chk(rd, 32'(DEF_DIV));
    apb(1'h0, OFS_IDPAT, 32'h0, rd, er);
    chk(rd, 32'h00003F00);
    apb(1'h0, 8'h40, 32'h0, rd, er);
    chk({rd[30:0], er}, 32'h1);
    apb(1'h1, OFS_BITDIV, 32'h4, rd, er);
    apb(1'h1, OFS_IDPAT, 32'h00003F01, rd, er);
    for (int k = 0; k < 13; k++) begin
      // Ordered compare: full-care pattern 0, then one bit masked
      if (k == 11) apb(1'h1, OFS_IDPAT, 32'h00003F00, rd, er);
      if (k == 12) apb(1'h1, OFS_IDPAT, 32'h00003E00, rd, er);
      run(rows[k]);
    end
    // Header with no response, then a response cut by capture stop
    apb(1'h1, OFS_CTRL, 32'h00000001, rd, er);
    lin.put_break();
    lin.put_byte(SYNC_VAL);
    lin.put_byte(8'hC1);
    wait_rec();
    chk(32'(record.status), 32'(ST_NO_DATA));
    lin.put_break();
    lin.put_byte(SYNC_VAL);
    lin.put_byte(8'hC1);
    lin.put_byte(8'h12);
    apb(1'h1, OFS_CTRL, 32'h00008001, rd, er);
    chk(32'(record.status), 32'(ST_TRUNCATED_FRAME));
    // Reset in mid-run clears outputs and control
    presetn <= 1'h0;
    @(posedge pclk);
    chk(32'({trigger, record_valid}), 32'h0);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, OFS_CTRL, 32'h0, rd, er);
    chk(rd, 32'h0);
    end_sim();
  end
  // Watchdog against a hung handshake or missing record
  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    end_sim();
  end
endmodule
